// [hdl/audio_dac_serial_input.sv]
// Converter end: clock ratio detect, init sequencing and serial receive
// Operation
// - Autodetect system clock ratio 256 to 768
// - Source gives faster clock at 128x modulator
// - No 512x or 768x at 192 kHz
// - Power-on init lasts 1024 system clocks
// - Mode settings default after any init
// - Controller holds reset low at least 20 ns
// - Reset rising edge starts 1024-clock init
// - Data shifted on bit clock rising edge
// - Word clock synchronous to system clock
// - Drift beyond six bit clocks reinitialises, zero
// - Format field selects justification and length
// - Format defaults to 24-bit I2S
// - Samples two's complement, MSB first
`timescale 1ns/10ps
`include "audio_serial_defines.svh"
module audio_dac_serial_input #(
   parameter int INIT_COUNT = `INIT_CYCLES,
   parameter int DRIFT_BCK = `DRIFT_LIMIT_BCK
) (
   input wire logic ref_clk,
   input wire logic reset,
   audio_serial_if.device link,
   input wire logic [2:0] formatSelect,
   input wire logic formatWrite,
   output logic [2:0] serialFormatSelect,
   output logic [9:0] clockRatio,
   output logic ready,
   output logic muteBipolarZero,
   output audio_serial_pkg::sample_t leftSample,
   output audio_serial_pkg::sample_t rightSample,
   output logic sampleValid
);
   initial begin
      if (INIT_COUNT < 1 || INIT_COUNT > 65535) $error("INIT_COUNT out of range");
      if (DRIFT_BCK < 1 || DRIFT_BCK > 31) $error("DRIFT_BCK out of range");
   end

   // Bits in a word for the selected format
   function automatic logic [5:0] wordLen(input logic [2:0] f);
      unique case (f)
         `FMT_RJ16: wordLen = 6'h10;
         `FMT_RJ20: wordLen = 6'h14;
         `FMT_RJ18: wordLen = 6'h12;
         default: wordLen = 6'h18;
      endcase
   endfunction

   // Two-flop synchronisers for the pins
   logic [1:0] bckS_q, lrS_q, datS_q, rstS_q;
   logic bckD_q, lrD_q, rstD_q;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bckS_q <= 2'h0;
         lrS_q <= 2'h0;
         datS_q <= 2'h0;
         rstS_q <= 2'h0;
         bckD_q <= 1'h0;
         lrD_q <= 1'h0;
         rstD_q <= 1'h0;
      end else begin
         bckS_q <= {bckS_q[0], link.audioBitClock};
         lrS_q <= {lrS_q[0], link.leftRightWordClock};
         datS_q <= {datS_q[0], link.serialData};
         rstS_q <= {rstS_q[0], link.resetN};
         bckD_q <= bckS_q[1];
         if (bckS_q[1] && !bckD_q) lrD_q <= lrS_q[1]; // Word clock at last bit clock rise
         rstD_q <= rstS_q[1];
      end
   end
   logic bckRise, lrEdge, extResetLow, extResetRise;
   assign bckRise = bckS_q[1] & ~bckD_q;
   assign lrEdge = bckRise & (lrS_q[1] ^ lrD_q);
   assign extResetLow = ~rstS_q[1];
   assign extResetRise = rstS_q[1] & ~rstD_q;

   // Init sequencer and drift watch
   audio_serial_pkg::rx_state_t state_q;
   logic [15:0] initCnt_q;
   logic [9:0] sysCnt_q, lastRatio_q;
   logic [7:0] bckCnt_q, lastBck_q;
   logic driftErr;
   assign driftErr = lrEdge & lrS_q[1] & (state_q == audio_serial_pkg::RUN) &
      ((bckCnt_q > lastBck_q + 8'(DRIFT_BCK)) ||
       (bckCnt_q + 8'(DRIFT_BCK) < lastBck_q));
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= audio_serial_pkg::INIT;
         initCnt_q <= 16'h0;
      end else if (extResetLow || extResetRise || driftErr) begin
         state_q <= audio_serial_pkg::INIT;
         initCnt_q <= 16'h0;
      end else begin
         unique case (state_q)
            audio_serial_pkg::INIT: begin
               initCnt_q <= initCnt_q + 16'h1;
               if (initCnt_q == 16'(INIT_COUNT - 1)) state_q <= audio_serial_pkg::LOCK;
            end
            audio_serial_pkg::LOCK: begin
               if (lrEdge && lrS_q[1] && lastRatio_q != 10'h0) state_q <= audio_serial_pkg::RUN;
            end
            audio_serial_pkg::RUN: ;
         endcase
      end
   end

   // Ratio detect: system clocks per word clock period
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         sysCnt_q <= 10'h0;
         lastRatio_q <= 10'h0;
         bckCnt_q <= 8'h0;
         lastBck_q <= 8'h0;
      end else if (state_q == audio_serial_pkg::INIT) begin
         sysCnt_q <= 10'h0;
         lastRatio_q <= 10'h0;
         bckCnt_q <= 8'h0;
         lastBck_q <= 8'h0;
      end else if (lrEdge && lrS_q[1]) begin
         sysCnt_q <= 10'h1;
         bckCnt_q <= 8'h1;
         lastBck_q <= bckCnt_q;
         if (sysCnt_q >= 10'(`RATIO_MIN) && sysCnt_q <= 10'(`RATIO_MAX))
            lastRatio_q <= sysCnt_q;
         else
            lastRatio_q <= 10'h0;
      end else begin
         if (sysCnt_q != 10'h3ff) sysCnt_q <= sysCnt_q + 10'h1;
         if (bckRise && bckCnt_q != 8'hff) bckCnt_q <= bckCnt_q + 8'h1;
      end
   end
   assign clockRatio = lastRatio_q;
   assign ready = (state_q == audio_serial_pkg::RUN);
   assign muteBipolarZero = ~ready;

   // Format field, back to default on every init
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) serialFormatSelect <= `FMT_RESET;
      else if (state_q == audio_serial_pkg::INIT) serialFormatSelect <= `FMT_RESET;
      else if (formatWrite) serialFormatSelect <= formatSelect;
   end

   // Serial shift and word alignment
   logic [31:0] shift_q;
   logic [5:0] bitIdx_q;
   logic chanLeft_q, pendLr_q;
   logic [5:0] len;
   logic isRj;
   assign len = wordLen(serialFormatSelect);
   assign isRj = serialFormatSelect[2] == 1'b0;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         shift_q <= 32'h0;
         bitIdx_q <= 6'h0;
         chanLeft_q <= 1'h0;
         pendLr_q <= 1'h0;
         leftSample <= 24'h0;
         rightSample <= 24'h0;
         sampleValid <= 1'h0;
      end else begin
         sampleValid <= 1'b0;
         if (!ready) begin
            leftSample <= 24'h0;
            rightSample <= 24'h0;
         end
         if (bckRise) begin
            shift_q <= {shift_q[30:0], datS_q[1]};
            if (isRj && (lrS_q[1] ^ lrD_q)) begin
               // Right-justified: last bits before the word clock edge are LSBs
               if (ready) begin
                  if (lrD_q == 1'b1) leftSample <= 24'(shift_q << (6'd24 - len));
                  else begin
                     rightSample <= 24'(shift_q << (6'd24 - len));
                     sampleValid <= 1'b1;
                  end
               end
            end else if (!isRj) begin
               if (lrS_q[1] ^ lrD_q) begin
                  // Left is word clock low in I2S, high otherwise
                  chanLeft_q <= (serialFormatSelect == `FMT_I2S) ? ~lrS_q[1] : lrS_q[1];
                  bitIdx_q <= 6'h0;
                  // I2S waits one bit clock, left-justified takes this bit
                  pendLr_q <= (serialFormatSelect == `FMT_I2S);
                  if (serialFormatSelect == `FMT_LJ) begin
                     shift_q <= {31'h0, datS_q[1]};
                     bitIdx_q <= 6'h1;
                  end
               end else if (pendLr_q) begin
                  pendLr_q <= 1'b0;
                  shift_q <= {31'h0, datS_q[1]};
                  bitIdx_q <= 6'h1;
               end else if (bitIdx_q != 6'h0 && bitIdx_q < 6'd24) begin
                  bitIdx_q <= bitIdx_q + 6'h1;
                  if (bitIdx_q == 6'd23 && ready) begin
                     if (chanLeft_q) leftSample <= {shift_q[22:0], datS_q[1]};
                     else begin
                        rightSample <= {shift_q[22:0], datS_q[1]};
                        sampleValid <= 1'b1;
                     end
                  end
               end
            end
         end
      end
   end
endmodule // audio_dac_serial_input

// [common/audio_serial_defines.svh]
// Timing counts, field codes and reset values for the serial audio front end
`ifndef AUDIO_SERIAL_DEFINES_SVH
`define AUDIO_SERIAL_DEFINES_SVH
`define INIT_CYCLES 1024
`define DRIFT_LIMIT_BCK 6
`define FMT_RJ16 3'h0
`define FMT_RJ20 3'h1
`define FMT_RJ24 3'h2
`define FMT_RJ18 3'h3
`define FMT_I2S 3'h4
`define FMT_LJ 3'h5
`define FMT_RESET 3'h4
`define RATIO_MIN 256
`define RATIO_MAX 768
`define SLOT_BITS 32
`endif

// [common/audio_serial_pkg.sv]
// Sample type shared by both ends of the serial audio link, receive states for the converter end
package audio_serial_pkg;
   typedef enum logic [1:0] {INIT, LOCK, RUN} rx_state_t;
   typedef logic [23:0] sample_t;
endpackage

// [common/audio_serial_if.sv]
// Four-wire serial audio link between source and converter front end
`timescale 1ns/10ps
interface audio_serial_if;
   logic audioBitClock;
   logic leftRightWordClock;
   logic serialData;
   logic resetN;
   modport source (output audioBitClock, output leftRightWordClock, output serialData,
      output resetN);
   modport device (input audioBitClock, input leftRightWordClock, input serialData,
      input resetN);
endinterface

// [hdl/audio_serial_source.sv]
// Source end: divides ref_clk into bit and word clocks, sends two's complement MSB first
`timescale 1ns/10ps
`include "audio_serial_defines.svh"
module audio_serial_source #(
   parameter int BCK_DIV = 4,
   parameter int RESET_LOW_NS = 20,
   parameter int CLK_NS = 25
) (
   input wire logic ref_clk,
   input wire logic reset,
   audio_serial_if.source link,
   input wire logic [2:0] serialFormatSelect,
   input wire logic resetRequest,
   input audio_serial_pkg::sample_t leftIn,
   input audio_serial_pkg::sample_t rightIn,
   output logic sampleTaken
);
   localparam int RESET_CYC = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS + 1;
   initial begin
      if (BCK_DIV < 2 || BCK_DIV > 255 || BCK_DIV % 2 != 0) $error("BCK_DIV unusable");
      if (64 * BCK_DIV < `RATIO_MIN || 64 * BCK_DIV > `RATIO_MAX)
         $error("clock ratio too low or too high");
      if (64 * BCK_DIV >= 512 && CLK_NS * 64 * BCK_DIV * 192 <= 1000000)
         $error("ratio unsupported at top sample rate");
   end

   // Bit clock divider, word clock after 32 bits per channel
   logic [7:0] div_q;
   logic [4:0] bit_q;
   logic bck_q, lr_q, dat_q, rstN_q;
   logic [31:0] shL_q, shR_q;
   logic [3:0] rstCnt_q;
   logic [5:0] len;
   logic isI2s, wordNext, leftNext;
   assign len = (serialFormatSelect == `FMT_RJ16) ? 6'd16 :
                (serialFormatSelect == `FMT_RJ20) ? 6'd20 :
                (serialFormatSelect == `FMT_RJ18) ? 6'd18 : 6'd24;
   assign isI2s = (serialFormatSelect == `FMT_I2S);
   // Word clock level and channel of the slot presented next
   assign wordNext = (bit_q == 5'h1f) ? lr_q : ~lr_q;
   assign leftNext = isI2s ? ~wordNext : wordNext;

   // Sample in a 32-slot word: right-justified at the bottom, else from the top
   function automatic logic [31:0] packWord(input audio_serial_pkg::sample_t v,
      input logic [2:0] f, input logic [5:0] n);
      if (f[2] == 1'b0) packWord = 32'(v >> (6'd24 - n));
      else packWord = {v, 8'h0};
   endfunction

   // Bit for slot s; the I2S word starts one slot late
   function automatic logic slotBit(input logic [31:0] w, input logic [4:0] s, input logic i2s);
      if (i2s) slotBit = (s == 5'h0) ? 1'b0 : w[5'(6'd32 - {1'b0, s})];
      else slotBit = w[5'h1f - s];
   endfunction

   // Reset pulse of at least the minimum width
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rstCnt_q <= 4'h0;
         rstN_q <= 1'b0;
      end else if (resetRequest) begin
         rstCnt_q <= 4'(RESET_CYC);
         rstN_q <= 1'b0;
      end else if (rstCnt_q != 4'h0) rstCnt_q <= rstCnt_q - 4'h1;
      else rstN_q <= 1'b1;
   end

   // Clocks and data are all derived from ref_clk, so word clock stays synchronous
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         div_q <= 8'h0;
         bit_q <= 5'h0;
         bck_q <= 1'b0;
         lr_q <= 1'b0;
         dat_q <= 1'b0;
         shL_q <= 32'h0;
         shR_q <= 32'h0;
         sampleTaken <= 1'b0;
      end else begin
         sampleTaken <= 1'b0;
         div_q <= (div_q == 8'(BCK_DIV / 2 - 1)) ? 8'h0 : div_q + 8'h1;
         if (div_q == 8'(BCK_DIV / 2 - 1)) begin
            bck_q <= ~bck_q;
            if (bck_q) begin
               // Falling edge: present next bit, MSB first
               bit_q <= bit_q + 5'h1;
               if (bit_q == 5'h1f) begin
                  lr_q <= ~lr_q;
                  // Reload the channel that is not on the wire next
                  if (leftNext) begin
                     shR_q <= packWord(rightIn, serialFormatSelect, len);
                     sampleTaken <= 1'b1;
                  end else shL_q <= packWord(leftIn, serialFormatSelect, len);
               end
               dat_q <= slotBit(leftNext ? shL_q : shR_q, bit_q + 5'h1, isI2s);
            end
         end
      end
   end
   assign link.audioBitClock = bck_q;
   assign link.leftRightWordClock = ~lr_q;
   assign link.serialData = dat_q;
   assign link.resetN = rstN_q;
endmodule // audio_serial_source

// [verification/audio_serial_checker.sv]
// Concurrent checks on the serial audio link and converter status
`timescale 1ns/10ps
module audio_serial_checker #(
   parameter int INIT_COUNT = 1024
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic audioBitClock,
   input wire logic leftRightWordClock,
   input wire logic serialData,
   input wire logic resetN,
   input wire logic ready,
   input wire logic muteBipolarZero,
   input wire logic sampleValid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic [15:0] initCnt_q;
   // Cycles since the link reset released, saturating
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) initCnt_q <= 16'h0000;
      else if (!resetN) initCnt_q <= 16'h0000;
      else if (initCnt_q != 16'hffff) initCnt_q <= initCnt_q + 16'h0001;
   end
   // Bit clock high phase of two cycles
   sequence s_bit_high;
      audioBitClock ##1 audioBitClock ##1 !audioBitClock;
   endsequence
   sequence s_no_valid;
      !sampleValid [*8];
   endsequence
   property p_data_setup; $rose(audioBitClock) |-> $stable(serialData); endproperty
   property p_word_setup; $rose(audioBitClock) |-> $stable(leftRightWordClock); endproperty
   property p_bit_shape; $rose(audioBitClock) |-> s_bit_high; endproperty
   property p_mute_level; muteBipolarZero == !ready; endproperty
   property p_init_len; $rose(ready) |-> initCnt_q >= INIT_COUNT; endproperty
   property p_reset_stop; $fell(resetN) |-> ##[1:4] !ready; endproperty
   property p_init_quiet; $rose(resetN) |-> !ready [*8]; endproperty
   property p_valid_pulse; sampleValid |-> ready ##1 s_no_valid; endproperty
   a_data_setup: assert property (p_data_setup)
      else $error("data moved at bit clock rise");
   a_word_setup: assert property (p_word_setup)
      else $error("word clock moved at bit clock rise");
   a_bit_shape: assert property (p_bit_shape)
      else $error("bit clock high phase wrong");
   a_mute_level: assert property (p_mute_level)
      else $error("mute not inverse of ready");
   a_init_len: assert property (p_init_len)
      else $error("init shorter than count");
   a_reset_stop: assert property (p_reset_stop)
      else $error("link reset did not stop run");
   a_init_quiet: assert property (p_init_quiet)
      else $error("ready during init");
   a_valid_pulse: assert property (p_valid_pulse)
      else $error("sample valid pulse wrong");
endmodule // audio_serial_checker

// [verification/tb.sv]
// Testbench joining source and converter ends, plus a drift stimulus link
`timescale 1ns/10ps
`include "audio_serial_defines.svh"
module tb;
   localparam int INIT_N = 16;
   localparam logic [23:0] LEFT_V = 24'h000321;
   localparam logic [23:0] RIGHT_V = 24'hfffabc;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] fmtSrc = `FMT_RESET;
   logic [2:0] fmtSel = `FMT_RESET;
   logic fmtWr = 1'b0;
   logic rstReq = 1'b0;
   logic [2:0] serialFormatSelect;
   logic [9:0] clockRatio;
   logic ready, mute, sampleValid, ready2, mute2, taken;
   audio_serial_pkg::sample_t leftSample, rightSample;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   audio_serial_if lnk();
   audio_serial_if lnk2();
   audio_serial_source i_audio_serial_source (.ref_clk(ref_clk), .reset(reset), .link(lnk),
      .serialFormatSelect(fmtSrc), .resetRequest(rstReq), .leftIn(LEFT_V), .rightIn(RIGHT_V),
      .sampleTaken(taken));
   audio_dac_serial_input #(.INIT_COUNT(INIT_N)) i_audio_dac_serial_input (.ref_clk(ref_clk),
      .reset(reset), .link(lnk), .formatSelect(fmtSel), .formatWrite(fmtWr),
      .serialFormatSelect(serialFormatSelect), .clockRatio(clockRatio), .ready(ready),
      .muteBipolarZero(mute), .leftSample(leftSample), .rightSample(rightSample),
      .sampleValid(sampleValid));
   audio_dac_serial_input #(.INIT_COUNT(INIT_N)) i_audio_dac_serial_input_b (.ref_clk(ref_clk),
      .reset(reset), .link(lnk2), .formatSelect(`FMT_RESET), .formatWrite(1'b0),
      .serialFormatSelect(), .clockRatio(), .ready(ready2), .muteBipolarZero(mute2),
      .leftSample(), .rightSample(), .sampleValid());
   audio_serial_checker #(.INIT_COUNT(INIT_N)) i_audio_serial_checker (.ref_clk(ref_clk),
      .reset(reset), .audioBitClock(lnk.audioBitClock),
      .leftRightWordClock(lnk.leftRightWordClock), .serialData(lnk.serialData),
      .resetN(lnk.resetN), .ready(ready), .muteBipolarZero(mute), .sampleValid(sampleValid));
   // Clock and hang guard
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bounded wait for ready or a sample pulse
   task automatic wait_on(input bit useValid);
      int i;
      i = 0;
      do begin
         @(negedge ref_clk);
         i++;
      end while (i < 4000 && (useValid ? sampleValid : ready) !== 1'b1);
      if (i == 4000) check("wait", 24'h0, 24'h1);
   endtask
   // Expected sample: shorter words keep only their top bits
   function automatic logic [23:0] trim(input logic [23:0] v, input logic [2:0] f);
      int n;
      n = (f == `FMT_RJ16) ? 16 : (f == `FMT_RJ20) ? 20 : (f == `FMT_RJ18) ? 18 : 24;
      trim = (v >> (24 - n)) << (24 - n);
   endfunction
   // One word pair on the stimulus link, bit clock period eight cycles
   task automatic frame(input int bits, input int half);
      for (int i = 0; i < bits; i++) begin
         @(posedge ref_clk);
         lnk2.audioBitClock <= 1'b0;
         lnk2.leftRightWordClock <= (i < half);
         lnk2.serialData <= i[0];
         repeat (4) @(posedge ref_clk);
         lnk2.audioBitClock <= 1'b1;
         repeat (3) @(posedge ref_clk);
      end
   endtask
   task automatic test_defaults();
      @(negedge ref_clk);
      check("format", serialFormatSelect, `FMT_RESET);
      check("mute", mute, 1'b1);
      check("left", leftSample, 24'h000000);
      $display("test_defaults done");
   endtask
   task automatic test_lock();
      wait_on(1'b0);
      repeat (2) wait_on(1'b1);
      check("ratio", clockRatio, 10'h100);
      check("left", leftSample, LEFT_V);
      check("right", rightSample, RIGHT_V);
      for (int i = 0; i < 600 && taken !== 1'b1; i++) @(negedge ref_clk);
      check("taken", taken, 1'b1);
      $display("test_lock done");
   endtask
   task automatic test_formats();
      for (int c = 0; c < 6; c++) begin
         @(posedge ref_clk);
         fmtSrc <= c[2:0];
         fmtSel <= c[2:0];
         fmtWr <= 1'b1;
         @(posedge ref_clk);
         fmtWr <= 1'b0;
         wait_on(1'b0);
         repeat (3) wait_on(1'b1);
         check("format", serialFormatSelect, c[2:0]);
         check("left", leftSample, trim(LEFT_V, c[2:0]));
         check("right", rightSample, trim(RIGHT_V, c[2:0]));
      end
      $display("test_formats done");
   endtask
   task automatic test_ext_reset();
      @(posedge ref_clk);
      rstReq <= 1'b1;
      @(posedge ref_clk);
      rstReq <= 1'b0;
      fmtSrc <= `FMT_RESET;
      repeat (8) @(negedge ref_clk);
      check("ready", ready, 1'b0);
      check("format", serialFormatSelect, `FMT_RESET);
      check("left", leftSample, 24'h000000);
      wait_on(1'b0);
      check("ready", ready, 1'b1);
      $display("test_ext_reset done");
   endtask
   task automatic test_drift();
      repeat (4) frame(64, 32);
      @(negedge ref_clk);
      check("ready2", ready2, 1'b1);
      frame(40, 20);
      frame(16, 32);
      @(negedge ref_clk);
      check("ready2", ready2, 1'b0);
      check("mute2", mute2, 1'b1);
      $display("test_drift done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      lnk2.audioBitClock = 1'b0;
      lnk2.leftRightWordClock = 1'b0;
      lnk2.serialData = 1'b0;
      lnk2.resetN = 1'b1;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      test_defaults();
      test_lock();
      test_formats();
      test_ext_reset();
      test_drift();
      complete_run();
   end
endmodule // tb
